// ===== rtl/mrc_pkg.sv
// Shared constants, types and register map of the measurement recording coupler
package mrc_pkg;

	// Clock and printed times
	localparam int CLK_NS        = 10;
	localparam int XFER_MIN_NS   = 524_000;
	localparam int XFER_MAX_NS   = 1_524_000;
	localparam int TAPE_CHAR_NS  = 2_000_000;
	localparam int PUNCH_CHAR_NS = 8_500_000;
	localparam int SCAN_ADV_NS   = 50_000;
	localparam int CMD_PULSE_NS  = 10_000;
	localparam int GAP_ACK_NS    = 1_000_000;

	// Cycle counts: least times round up, longest times round down
	localparam int XFER_MIN_CYC   = (XFER_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int XFER_MAX_CYC   = XFER_MAX_NS / CLK_NS;
	localparam int XFER_SEL_MAX   = 255;
	localparam int XFER_STEP_CYC  = (XFER_MAX_CYC - XFER_MIN_CYC) / XFER_SEL_MAX;
	localparam int TAPE_CHAR_CYC  = (TAPE_CHAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int PUNCH_CHAR_CYC = (PUNCH_CHAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCAN_ADV_CYC   = (SCAN_ADV_NS + CLK_NS - 1) / CLK_NS;
	localparam int CMD_PULSE_CYC  = (CMD_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_ACK_CYC    = (GAP_ACK_NS + CLK_NS - 1) / CLK_NS;

	localparam int TMR_W = 24;
	localparam int CNT_W = 10;

	// Register byte offsets
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_GROUP  = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;

	// Control register fields
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_PUNCH_BIT = 1;
	localparam int CTRL_MODE_LSB  = 2;
	localparam int CTRL_NOW_BIT   = 4;
	localparam int CTRL_XFER_LSB  = 8;

	// Status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_READY_BIT = 3;
	localparam int STAT_GAP_BIT   = 4;
	localparam int STAT_NRDY_BIT  = 5;
	localparam int STAT_BUSY_BIT  = 6;
	localparam int STAT_RUN_BIT   = 7;
	localparam int STAT_WCNT_LSB  = 16;

	// Reset values
	localparam logic             EN_RST    = 1'b1;
	localparam logic             PUNCH_RST = 1'b0;
	localparam logic [7:0]       XFER_RST  = 8'h00;
	localparam logic [CNT_W-1:0] GROUP_RST = 10'h00a;

	// Nibble shown while the punch records its carriage return marker
	localparam logic [3:0] CR_NIBBLE = 4'hf;

	typedef enum logic [1:0] {
		GRP_PROG      = 2'h0,
		GRP_WORDS     = 2'h1,
		GRP_SCANS     = 2'h2,
		GRP_WORDS_EOS = 2'h3
	} mrc_group_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOAD = 3'h1,
		ST_ADV  = 3'h3,
		ST_PRES = 3'h2,
		ST_CMD  = 3'h6,
		ST_WAIT = 3'h7,
		ST_CTRL = 3'h5,
		ST_HOLD = 3'h4
	} mrc_state_t;

	typedef struct packed {
		logic [3:0] chr;
		logic       cr;
		logic       cmd;
		logic       gap_req;
	} mrc_rec_t;

	typedef struct packed {
		logic gap;
		logic not_ready;
		logic busy;
	} mrc_hold_t;

endpackage

// ===== rtl/mrc_sync.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/100ps
module mrc_sync #(
	parameter int W = 1
)(
	input  wire logic         ref_clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;

	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					s1_reg[b] <= 1'b0;
					s2_reg[b] <= 1'b0;
					s3_reg[b] <= 1'b0;
					q_reg[b]  <= 1'b0;
				end else begin
					s1_reg[b] <= d_i[b];
					s2_reg[b] <= s1_reg[b];
					s3_reg[b] <= s2_reg[b];
					if (s2_reg[b] == s3_reg[b]) begin
						q_reg[b] <= s3_reg[b];
					end
				end
			end
		end
	endgenerate

	assign q_o = q_reg;
endmodule

// ===== rtl/mrc_timer.sv
// Down counter: done goes high the given number of cycles after a load
`timescale 1ns/100ps
module mrc_timer
	import mrc_pkg::*;
(
	input  wire logic             ref_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             load_i,
	input  wire logic [TMR_W-1:0] value_i,
	output logic                  done_o
);
	logic [TMR_W-1:0] cnt_reg;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_reg <= '0;
		end else if (load_i) begin
			cnt_reg <= value_i;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign done_o = (cnt_reg == '0);
endmodule

// ===== rtl/mrc_coupler.sv
// Coupler: takes a reading and channel code in parallel, then records them one character at a time
//
// Functional notes
// - Reading and channel code are loaded together, all bits in parallel.
// - Input transfer time is set by software between 0.524 ms and 1.524 ms.
// - Stored characters go out one at a time, each with a command pulse.
// - No new reading is taken until every character has been sent.
// - Tape recording budgets 2 ms per character.
// - Punch recording expects 8.5 ms per character.
// - Tape step commands are spaced by an internal 2 ms interval.
// - A formatting control character is inserted at programmed intervals.
// - On tape the control character is a gap request line pulse.
// - While a gap is in progress no new reading is accepted.
// - Next punch command and character wait until punch busy is removed.
// - On the punch the control character is a carriage return, same handshake.
// - Every decimal digit travels as four bits weighted 8-4-2-1.
// - An end-of-word pulse follows the last character of each word.
// - A channel-advance pulse goes to the scanner before characters are sent.
// - Software-held counts set how many words or scans separate control characters.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
module mrc_coupler
	import mrc_pkg::*;
#(
	parameter int RDG_DIGITS = 5,
	parameter int CH_DIGITS  = 3,
	parameter int XFER_MIN   = XFER_MIN_CYC,
	parameter int XFER_STEP  = XFER_STEP_CYC,
	parameter int TAPE_CHAR  = TAPE_CHAR_CYC,
	parameter int PUNCH_CHAR = PUNCH_CHAR_CYC,
	parameter int SCAN_ADV   = SCAN_ADV_CYC,
	parameter int GAP_ACK    = GAP_ACK_CYC
)(
	input  wire logic                    ref_clk_i,
	input  wire logic                    resetn_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    meas_done_i,
	input  wire logic                    pass_end_indication_i,
	input  wire mrc_hold_t               hold_i,
	input  wire logic [RDG_DIGITS*4-1:0] rdg_bcd_i,
	input  wire logic [CH_DIGITS*4-1:0]  chan_bcd_i,
	output mrc_rec_t                     rec_o,
	output logic                         scan_advance_o,
	output logic                         word_end_indication_o,
	output logic                         ready_o
);
	localparam int N_CHAR = RDG_DIGITS + CH_DIGITS;
	localparam int IDX_W  = $clog2(N_CHAR);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_CHAR - 1);

	// Synchronised pins
	logic      meas_s;
	logic      eos_s;
	mrc_hold_t hold_s;
	logic      meas_d_reg;
	logic      eos_d_reg;
	logic      meas_rise;
	logic      eos_rise;
	logic      hold_any;

	// Software registers
	logic             en_reg;
	logic             punch_reg;
	mrc_group_t       mode_reg;
	logic [7:0]       xfer_sel_reg;
	logic [CNT_W-1:0] group_reg;
	logic             now_pend_reg;

	// Sequencer state
	mrc_state_t       state_reg;
	mrc_state_t       state_next;
	logic [IDX_W-1:0] idx_reg;
	logic [IDX_W-1:0] idx_next;
	logic [3:0]       char_mem [N_CHAR];
	logic [N_CHAR*4-1:0] cap_word;
	mrc_rec_t         rec_reg;
	mrc_rec_t         rec_next;
	logic             scan_adv_reg;
	logic             scan_adv_next;
	logic             word_end_reg;
	logic             word_end_next;
	logic             is_ctrl_reg;
	logic             is_ctrl_next;
	logic             flag_seen_reg;
	logic             flag_seen_next;
	logic             gap_seen_reg;
	logic             gap_seen_next;
	logic             ready_reg;
	logic             meas_pend_reg;
	logic             eos_pend_reg;
	logic             word_eos_reg;
	logic [CNT_W-1:0] word_cnt_reg;
	logic [CNT_W-1:0] scan_cnt_reg;

	// Timer control
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic             tmr_done;
	logic             load_now;
	logic             word_done;
	logic             start_xfer;
	logic             char_ok;

	// Bus decode
	logic        wb_hit;
	logic        wb_wr;
	logic        hit_ctrl;
	logic        hit_group;
	logic        hit_status;
	logic [31:0] rd_data;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] dat_reg;
	logic        ack_reg;

	// Grouping decisions
	logic [CNT_W-1:0] word_cnt_inc;
	logic [CNT_W-1:0] scan_cnt_inc;
	logic             words_hit;
	logic             scans_hit;
	logic             ctrl_due;
	logic [TMR_W-1:0] xfer_cyc;

	mrc_sync #(
		.W (5)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.d_i       ({meas_done_i, pass_end_indication_i, hold_i}),
		.q_o       ({meas_s, eos_s, hold_s})
	);

	mrc_timer u_timer (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.load_i    (tmr_load),
		.value_i   (tmr_val),
		.done_o    (tmr_done)
	);

	assign meas_rise = meas_s & ~meas_d_reg;
	assign eos_rise  = eos_s & ~eos_d_reg;
	assign hold_any  = hold_s.gap | hold_s.not_ready;
	assign cap_word  = {chan_bcd_i, rdg_bcd_i};

	assign xfer_cyc = TMR_W'(XFER_MIN) + TMR_W'(xfer_sel_reg) * TMR_W'(XFER_STEP);

	assign word_cnt_inc = word_cnt_reg + 1'b1;
	assign scan_cnt_inc = scan_cnt_reg + 1'b1;
	assign words_hit    = (word_cnt_inc >= group_reg);
	assign scans_hit    = word_eos_reg && (scan_cnt_inc >= group_reg);
	assign ctrl_due     = (mode_reg == GRP_WORDS)     ? words_hit :
	                      (mode_reg == GRP_SCANS)     ? scans_hit :
	                      (mode_reg == GRP_WORDS_EOS) ? (words_hit | word_eos_reg) :
	                      now_pend_reg;

	assign start_xfer = (state_reg == ST_IDLE) && (state_next == ST_LOAD);
	assign char_ok    = punch_reg ? (tmr_done && flag_seen_reg && !hold_s.busy)
	                              : tmr_done;

	// Sequencer
	always_comb begin
		state_next     = state_reg;
		idx_next       = idx_reg;
		rec_next       = rec_reg;
		scan_adv_next  = scan_adv_reg;
		word_end_next  = 1'b0;
		is_ctrl_next   = is_ctrl_reg;
		flag_seen_next = flag_seen_reg;
		gap_seen_next  = gap_seen_reg;
		tmr_load       = 1'b0;
		tmr_val        = '0;
		load_now       = 1'b0;
		word_done      = 1'b0;
		if (hold_s.busy && (state_reg == ST_CMD || state_reg == ST_WAIT)) begin
			flag_seen_next = 1'b1;
		end
		if (hold_s.gap && state_reg == ST_HOLD) begin
			gap_seen_next = 1'b1;
		end
		case (state_reg)
			ST_IDLE: begin
				if (en_reg && meas_pend_reg && !hold_any) begin
					state_next = ST_LOAD;
					tmr_load   = 1'b1;
					tmr_val    = xfer_cyc;
				end
			end
			ST_LOAD: begin
				if (tmr_done) begin
					load_now      = 1'b1;
					scan_adv_next = 1'b1;
					tmr_load      = 1'b1;
					tmr_val       = TMR_W'(SCAN_ADV);
					state_next    = ST_ADV;
				end
			end
			ST_ADV: begin
				if (tmr_done) begin
					scan_adv_next = 1'b0;
					idx_next      = '0;
					is_ctrl_next  = 1'b0;
					rec_next.chr  = char_mem[0];
					rec_next.cr   = 1'b0;
					state_next    = ST_PRES;
				end
			end
			ST_PRES: begin
				// Character has stood for a cycle before the command rises
				rec_next.cmd   = 1'b1;
				flag_seen_next = 1'b0;
				tmr_load       = 1'b1;
				// The loading edge already counts, so a pulse of N cycles loads N - 1
				tmr_val        = TMR_W'(CMD_PULSE_CYC - 1);
				state_next     = ST_CMD;
			end
			ST_CMD: begin
				if (tmr_done) begin
					rec_next.cmd = 1'b0;
					tmr_load     = 1'b1;
					// Two sequencing cycles come off so command starts sit one slot apart
					tmr_val      = punch_reg ? TMR_W'(PUNCH_CHAR - CMD_PULSE_CYC - 2)
					                         : TMR_W'(TAPE_CHAR - CMD_PULSE_CYC - 2);
					state_next   = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (char_ok) begin
					if (is_ctrl_reg) begin
						rec_next.cr  = 1'b0;
						is_ctrl_next = 1'b0;
						state_next   = ST_IDLE;
					end else if (idx_reg == LAST_IDX) begin
						word_done     = 1'b1;
						word_end_next = 1'b1;
						if (ctrl_due && punch_reg) begin
							is_ctrl_next = 1'b1;
							rec_next.cr  = 1'b1;
							rec_next.chr = CR_NIBBLE;
							state_next   = ST_PRES;
						end else if (ctrl_due) begin
							state_next = ST_CTRL;
						end else begin
							state_next = ST_IDLE;
						end
					end else begin
						idx_next     = idx_reg + 1'b1;
						rec_next.chr = char_mem[idx_reg + 1'b1];
						state_next   = ST_PRES;
					end
				end
			end
			ST_CTRL: begin
				if (!hold_any) begin
					rec_next.gap_req = 1'b1;
					gap_seen_next    = 1'b0;
					tmr_load         = 1'b1;
					tmr_val          = TMR_W'(CMD_PULSE_CYC - 1);
					state_next       = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (rec_reg.gap_req) begin
					if (tmr_done) begin
						rec_next.gap_req = 1'b0;
						tmr_load         = 1'b1;
						tmr_val          = TMR_W'(GAP_ACK);
					end
				end else if (gap_seen_reg ? !hold_s.gap : tmr_done) begin
					// Gap end, or the recorder never raised its hold-off in time
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Parallel capture of all digits at one edge
	genvar c;
	generate
		for (c = 0; c < N_CHAR; c++) begin : g_char
			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					char_mem[c] <= 4'h0;
				end else if (load_now) begin
					char_mem[c] <= cap_word[(N_CHAR-1-c)*4 +: 4];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg     <= ST_IDLE;
			idx_reg       <= '0;
			rec_reg       <= '0;
			scan_adv_reg  <= 1'b0;
			word_end_reg  <= 1'b0;
			is_ctrl_reg   <= 1'b0;
			flag_seen_reg <= 1'b0;
			gap_seen_reg  <= 1'b0;
			ready_reg     <= 1'b0;
			meas_d_reg    <= 1'b0;
			eos_d_reg     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			idx_reg       <= idx_next;
			rec_reg       <= rec_next;
			scan_adv_reg  <= scan_adv_next;
			word_end_reg  <= word_end_next;
			is_ctrl_reg   <= is_ctrl_next;
			flag_seen_reg <= flag_seen_next;
			gap_seen_reg  <= gap_seen_next;
			ready_reg     <= (state_next == ST_IDLE) && en_reg && !hold_any;
			meas_d_reg    <= meas_s;
			eos_d_reg     <= eos_s;
		end
	end

	// Pending events: a new measurement edge in the clearing cycle is kept; a pass end in that cycle goes to the word being loaded
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meas_pend_reg <= 1'b0;
			eos_pend_reg  <= 1'b0;
			word_eos_reg  <= 1'b0;
		end else begin
			meas_pend_reg <= meas_rise | (meas_pend_reg & ~start_xfer);
			eos_pend_reg  <= load_now ? 1'b0 : (eos_pend_reg | eos_rise);
			if (load_now) begin
				word_eos_reg <= eos_pend_reg | eos_rise;
			end
		end
	end

	// Word and scan counters restart whenever they trigger a control character
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			word_cnt_reg <= '0;
			scan_cnt_reg <= '0;
		end else if (word_done) begin
			word_cnt_reg <= (ctrl_due && mode_reg != GRP_SCANS) ? '0 : word_cnt_inc;
			if (word_eos_reg) begin
				scan_cnt_reg <= scans_hit ? '0 : scan_cnt_inc;
			end
		end
	end

	// Wishbone slave: answers every access, mapped or not, one cycle after the strobe
	assign wb_hit     = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wb_wr      = wb_hit & wb_we_i;
	assign hit_ctrl   = (wb_adr_i == ADR_CTRL);
	assign hit_group  = (wb_adr_i == ADR_GROUP);
	assign hit_status = (wb_adr_i == ADR_STATUS);

	assign ctrl_word = {16'h0000, xfer_sel_reg, 3'h0, 1'b0, mode_reg, punch_reg, en_reg};
	assign status_word = {6'h00, word_cnt_reg, 8'h00, rec_reg.cmd | rec_reg.gap_req,
	                      hold_s.busy, hold_s.not_ready, hold_s.gap, ready_reg, state_reg};
	assign rd_data = hit_ctrl   ? ctrl_word :
	                 hit_group  ? {22'h000000, group_reg} :
	                 hit_status ? status_word : 32'h0000_0000;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_hit;
			if (wb_hit && !wb_we_i) begin
				dat_reg <= rd_data;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_reg       <= EN_RST;
			punch_reg    <= PUNCH_RST;
			mode_reg     <= GRP_WORDS;
			xfer_sel_reg <= XFER_RST;
			group_reg    <= GROUP_RST;
		end else if (wb_wr) begin
			if (hit_ctrl && wb_sel_i[0]) begin
				en_reg    <= wb_dat_i[CTRL_EN_BIT];
				punch_reg <= wb_dat_i[CTRL_PUNCH_BIT];
				mode_reg  <= mrc_group_t'(wb_dat_i[CTRL_MODE_LSB +: 2]);
			end
			if (hit_ctrl && wb_sel_i[1]) begin
				xfer_sel_reg <= wb_dat_i[CTRL_XFER_LSB +: 8];
			end
			if (hit_group && wb_sel_i[0]) begin
				group_reg[7:0] <= wb_dat_i[7:0];
			end
			if (hit_group && wb_sel_i[1]) begin
				group_reg[CNT_W-1:8] <= wb_dat_i[CNT_W-1:8];
			end
		end
	end

	// External control request in PROG mode; a new request wins over the clear
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			now_pend_reg <= 1'b0;
		end else if (wb_wr && hit_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_NOW_BIT]) begin
			now_pend_reg <= 1'b1;
		end else if (word_done && mode_reg == GRP_PROG) begin
			now_pend_reg <= 1'b0;
		end
	end

	assign wb_ack_o              = ack_reg;
	assign wb_dat_o              = dat_reg;
	assign rec_o                 = rec_reg;
	assign scan_advance_o        = scan_adv_reg;
	assign word_end_indication_o = word_end_reg;
	assign ready_o               = ready_reg;
endmodule

// ===== verif/mrc_coupler_properties.sv
// Concurrent checks on the coupler's recording-side ports
`timescale 1ns/100ps
module mrc_coupler_properties
	import mrc_pkg::*;
#(
	parameter int TAPE_CHAR  = TAPE_CHAR_CYC,
	parameter int PUNCH_CHAR = PUNCH_CHAR_CYC
)(
	input wire logic      ref_clk_i,
	input wire logic      resetn_i,
	input wire mrc_hold_t hold_i,
	input wire mrc_rec_t  rec_o,
	input wire logic      scan_advance_o,
	input wire logic      word_end_indication_o,
	input wire logic      ready_o
);
	localparam int GAP_MIN = (TAPE_CHAR < PUNCH_CHAR) ? TAPE_CHAR : PUNCH_CHAR;
	logic        cmd_d_reg;
	logic [31:0] since_reg;

	// Cycles since the last command start, saturating so the first command passes
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_d_reg <= 1'b0;
			since_reg <= 32'h00ff_ffff;
		end else begin
			cmd_d_reg <= rec_o.cmd;
			if (rec_o.cmd && !cmd_d_reg)
				since_reg <= 32'h0;
			else if (since_reg != 32'h00ff_ffff)
				since_reg <= since_reg + 32'h1;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_adv_done;
		$fell(scan_advance_o);
	endsequence
	sequence s_first_step;
		!rec_o.cmd ##1 rec_o.cmd;
	endsequence

	property p_adv_then_step;
		s_adv_done |-> s_first_step;
	endproperty
	property p_step_width;
		$rose(rec_o.cmd) |-> rec_o.cmd[*8];
	endproperty
	property p_chr_held;
		rec_o.cmd |-> $stable(rec_o.chr);
	endproperty
	property p_step_spacing;
		$rose(rec_o.cmd) |-> since_reg >= GAP_MIN - 1;
	endproperty
	property p_no_adv_busy;
		$rose(scan_advance_o) |-> !rec_o.cmd && !rec_o.gap_req;
	endproperty
	property p_hold_ready;
		(hold_i.gap || hold_i.not_ready)[*6] |-> !ready_o;
	endproperty
	property p_busy_stops;
		hold_i.busy[*6] |-> !$rose(rec_o.cmd);
	endproperty
	property p_cr_code;
		rec_o.cr |-> rec_o.chr == CR_NIBBLE;
	endproperty
	property p_word_end_pulse;
		word_end_indication_o |=> !word_end_indication_o;
	endproperty
	property p_not_both;
		!(rec_o.cmd && rec_o.gap_req);
	endproperty

	a_adv_then_step: assert property (p_adv_then_step) else $error("no step after advance");
	a_step_width: assert property (p_step_width) else $error("command pulse too short");
	a_chr_held: assert property (p_chr_held) else $error("char moved under command");
	a_step_spacing: assert property (p_step_spacing) else $error("commands too close");
	a_no_adv_busy: assert property (p_no_adv_busy) else $error("reading taken mid word");
	a_hold_ready: assert property (p_hold_ready) else $error("ready under hold-off");
	a_busy_stops: assert property (p_busy_stops) else $error("command under busy");
	a_cr_code: assert property (p_cr_code) else $error("bad control char code");
	a_word_end_pulse: assert property (p_word_end_pulse) else $error("word end too long");
	a_not_both: assert property (p_not_both) else $error("gap and step together");
endmodule

bind mrc_coupler mrc_coupler_properties #(.TAPE_CHAR(TAPE_CHAR), .PUNCH_CHAR(PUNCH_CHAR)) u_props (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hold_i(hold_i), .rec_o(rec_o),
	.scan_advance_o(scan_advance_o), .word_end_indication_o(word_end_indication_o),
	.ready_o(ready_o));

// ===== verif/mrc_recorder_model.sv
// Behavioural recorder and punch answering step, punch and gap commands
`timescale 1ns/100ps
module mrc_recorder_model
	import mrc_pkg::*;
#(
	parameter int GAP_LEN = 3000
)(
	input  wire logic        ref_clk_i,
	input  wire mrc_rec_t    rec_i,
	input  wire logic        punch_i,
	input  wire logic        not_ready_i,
	input  wire logic [15:0] busy_len_i,
	output mrc_hold_t        hold_o
);
	logic        cmd_d_reg = 1'b0;
	logic        gap_d_reg = 1'b0;
	logic [15:0] busy_reg  = 16'h0;
	logic [15:0] gap_reg   = 16'h0;

	// Gap length is shortened; it only has to outlast the request pulse
	always @(posedge ref_clk_i) begin
		cmd_d_reg <= rec_i.cmd;
		gap_d_reg <= rec_i.gap_req;
		if (punch_i && rec_i.cmd && !cmd_d_reg)
			busy_reg <= busy_len_i;
		else if (busy_reg != 16'h0)
			busy_reg <= busy_reg - 16'h1;
		if (rec_i.gap_req && !gap_d_reg)
			gap_reg <= 16'(GAP_LEN);
		else if (gap_reg != 16'h0)
			gap_reg <= gap_reg - 16'h1;
	end
	assign hold_o = {gap_reg != 16'h0, not_ready_i, busy_reg != 16'h0};
endmodule

// ===== verif/measurement_recording_coupler_test.sv
// Self-checking bench for the measurement recording coupler
`timescale 1ns/100ps
module measurement_recording_coupler_test import mrc_pkg::*;;
	localparam int TCH = 1100;
	localparam int PCH = 1100;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'hf;
	logic        pass_end_indication = 1'b0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic [31:0] rd;
	logic        wb_ack;
	logic        meas = 1'b0;
	logic        nrdy = 1'b0;
	logic        punch = 1'b0;
	logic [15:0] busy_len = 16'h012c;
	logic [19:0] rdg = 20'h12345;
	logic [11:0] chan = 12'h678;
	mrc_hold_t   hold;
	mrc_rec_t    rec;
	logic        adv;
	logic        wend;
	logic        rdy;
	int          cyc_n = 0;
	int          checks = 0;
	int          mismatches = 0;

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc_n <= cyc_n + 1;

	mrc_coupler #(.XFER_MIN(20), .XFER_STEP(1), .TAPE_CHAR(TCH), .PUNCH_CHAR(PCH),
		.SCAN_ADV(10), .GAP_ACK(50)) u_dut (
		.ref_clk_i(ref_clk), .resetn_i(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .meas_done_i(meas),
		.pass_end_indication_i(pass_end_indication), .hold_i(hold), .rdg_bcd_i(rdg), .chan_bcd_i(chan),
		.rec_o(rec), .scan_advance_o(adv), .word_end_indication_o(wend), .ready_o(rdy));
	mrc_recorder_model u_rec (.ref_clk_i(ref_clk), .rec_i(rec), .punch_i(punch),
		.not_ready_i(nrdy), .busy_len_i(busy_len), .hold_o(hold));

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return rec.cmd;
			1: return adv;
			2: return wend;
			3: return rec.gap_req;
			default: return rdy;
		endcase
	endfunction

	task automatic wait_lvl(input int k, input logic lvl);
		int n;
		n = 0;
		while (pick(k) !== lvl && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20000) begin
			check("wait", k, 32'hff);
			close_out();
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 50) begin
			check("ack", 0, 1);
			close_out();
		end
	endtask

	task automatic pulse_meas();
		meas <= 1'b1;
		repeat (6) @(posedge ref_clk);
		meas <= 1'b0;
	endtask

	// Eight characters: channel digits then reading digits, most significant first
	task automatic get_word(input int space, input logic exact);
		int t;
		logic [31:0] w;
		t = 0;
		w = {chan, rdg};
		wait_lvl(1, 1'b1);
		check("cmd at advance", 32'(rec.cmd), 0);
		for (int i = 0; i < 8; i++) begin
			wait_lvl(0, 1'b0);
			wait_lvl(0, 1'b1);
			check("char", 32'(rec.chr), 32'(w[31-4*i -: 4]));
			if (i > 0 && exact)
				check("tape spacing", cyc_n - t, space);
			if (i > 0 && !exact)
				check("punch spacing", 32'((cyc_n - t) >= space), 1);
			t = cyc_n;
		end
		wait_lvl(2, 1'b1);
	endtask

	task automatic t_regs();
		wb(1'b0, ADR_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0000_0005);
		wb(1'b0, ADR_GROUP, 32'h0);
		check("group reset", rd, 32'h0000_000a);
		wb(1'b0, 8'h0c, 32'h0);
		check("unmapped", rd, 32'h0);
		wb(1'b1, ADR_GROUP, 32'h0000_0001);
		wb(1'b1, ADR_CTRL, 32'h0000_1001);
		wb(1'b0, ADR_CTRL, 32'h0);
		check("ctrl back", rd, 32'h0000_1001);
		wb_sel <= 4'h1;
		wb(1'b1, ADR_CTRL, 32'h0000_2001);
		wb_sel <= 4'hf;
		wb(1'b0, ADR_CTRL, 32'h0);
		check("lane 1 masked", rd, 32'h0000_1001);
		$display("regs done");
	endtask

	// Second reading arrives mid word and must wait for the word to finish
	task automatic t_tape();
		int t;
		t = cyc_n;
		pulse_meas();
		wait_lvl(1, 1'b1);
		check("xfer min", 32'((cyc_n - t) >= 36), 1);
		check("xfer max", 32'((cyc_n - t) <= 50), 1);
		pulse_meas();
		get_word(TCH, 1'b1);
		get_word(TCH, 1'b1);
		$display("tape done");
	endtask

	task automatic t_nrdy();
		nrdy <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("ready held", 32'(rdy), 0);
		pulse_meas();
		repeat (200) @(posedge ref_clk);
		check("advance held", 32'(adv), 0);
		nrdy <= 1'b0;
		get_word(TCH, 1'b1);
		$display("not ready done");
	endtask

	task automatic t_gap();
		int n;
		n = 0;
		wb(1'b1, ADR_CTRL, 32'h0000_1005);
		pulse_meas();
		get_word(TCH, 1'b1);
		wait_lvl(3, 1'b1);
		check("step in gap", 32'(rec.cmd), 0);
		wait_lvl(3, 1'b0);
		// Second word counts scans: one pass ends, so a gap must follow it
		wb(1'b1, ADR_CTRL, 32'h0000_1009);
		pass_end_indication <= 1'b1;
		pulse_meas();
		pass_end_indication <= 1'b0;
		while (hold.gap === 1'b1 && n < 20000) begin
			if (adv === 1'b1)
				check("advance in gap", 32'(adv), 0);
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20000) begin
			check("gap end", 0, 1);
			close_out();
		end
		get_word(TCH, 1'b1);
		wait_lvl(3, 1'b1);
		wait_lvl(3, 1'b0);
		wait_lvl(4, 1'b1);
		$display("gap done");
	endtask

	task automatic t_punch();
		wb(1'b1, ADR_CTRL, 32'h0000_1003);
		punch <= 1'b1;
		pulse_meas();
		get_word(PCH, 1'b0);
		busy_len <= 16'h07d0;
		wb(1'b1, ADR_CTRL, 32'h0000_1013);
		pulse_meas();
		get_word(2000, 1'b0);
		wait_lvl(0, 1'b1);
		check("cr flag", 32'(rec.cr), 1);
		check("cr code", 32'(rec.chr), 32'(CR_NIBBLE));
		$display("punch done");
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		t_regs();
		t_tape();
		t_nrdy();
		t_gap();
		t_punch();
		close_out();
	end
endmodule
